/* core/tfs_pkg.sv */
// package for the task file status register block
`default_nettype none
package tfs_pkg;
   // register select codes on the task file port (chosen)
   localparam logic [2:0] TFS_SEL_ERR  = 3'h1;
   localparam logic [2:0] TFS_SEL_FEAT = 3'h1;
   localparam logic [2:0] TFS_SEL_CNT  = 3'h2;
   localparam logic [2:0] TFS_SEL_NUM  = 3'h3;
   localparam logic [2:0] TFS_SEL_DEVH = 3'h6;
   localparam logic [2:0] TFS_SEL_STAT = 3'h7;

   // device/head field positions
   localparam int DH_FIX_HI  = 7;
   localparam int DH_LBA_BIT = 6;
   localparam int DH_FIX_LO  = 5;
   localparam int DH_UNIT    = 4;

   // error register field positions
   localparam int ER_CRC  = 7;
   localparam int ER_UNC  = 6;
   localparam int ER_SECTOR_ID_MISSING = 4;
   localparam int ER_ABT  = 2;
   localparam int ER_TK0  = 1;

   // status register field positions
   localparam int ST_BUSY = 7;
   localparam int ST_RDY  = 6;
   localparam int ST_DSC  = 4;
   localparam int ST_DRQ  = 3;
   localparam int ST_IDX  = 1;
   localparam int ST_ERR  = 0;

   // reset values and the error register read mask
   localparam logic [7:0] RST_STAT = 8'h50;
   localparam logic [7:0] RST_DEVH = 8'hA0;
   localparam logic [7:0] RST_CNT  = 8'h01;
   localparam logic [7:0] RST_NUM  = 8'h01;
   localparam logic [7:0] RST_DIAG = 8'h01;
   localparam logic [7:0] ER_ZERO_MASK = 8'hD6;

   // host access to the task file
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [2:0] sel;
      logic [7:0] wdata;
   } tfs_host_s;

   // completion report from the command engine
   typedef struct packed {
      logic        done;
      logic        fail;
      logic        diag;
      logic [7:0]  diag_code;
      logic        crc_err;
      logic        unc_err;
      logic        sector_id_missing_err;
      logic        abort_err;
      logic        tk0_err;
      logic [15:0] remain;
      logic [3:0]  head;
      logic [7:0]  sector;
      logic [7:0]  sector_prev;
   } tfs_cmpl_s;

   typedef struct packed {
      logic [7:0] devh;
      logic [7:0] err;
      logic [7:0] feat;
      logic [7:0] cnt;
      logic [7:0] cnt_prev;
      logic [7:0] num;
      logic [7:0] num_prev;
      logic       busy;
      logic       rdy;
      logic       rdy_hold;
      logic       seek_complete_flag;
      logic       dsc_hold;
      logic       data_request_flag;
      logic       idx;
      logic       errf;
      logic       irq;
      logic [7:0] rdata;
      logic       cmd_start;
   } tfs_state_s;
endpackage : tfs_pkg
`default_nettype wire

/* core/tfs_regs.sv */
// task file device/head, error, count, number and status registers
`default_nettype none
// Functional notes
// [R1] bit 6 picks chs or lba mode
// [R2] bits 7 and 5 fixed at one
// [R3] unit select bit ignored, always respond
// [R4] chs head bits rewritten at completion
// [R5] lba bits 24-27 rewritten at completion
// [R6] error valid after commands, diag code otherwise; reads mask bits 5,3,0 of the diag code too, so reset 01h reads 00h
// [R7] bit 7 on link crc fault
// [R8] bit 6 on uncorrectable data
// [R9] bit 4 when sector id missing
// [R10] bit 2 on aborted command
// [R11] bit 1 when track zero missing
// [R12] error bits 5,3,0 read zero
// [R13] count and previous count both zero means 65536
// [R14] count zero on success, remainder on failure
// [R15] sector number lba 0-7, previous 24-31
// [R16] status updated, status read clears interrupt
// [R17] busy makes every read return status
// [R18] ready held clear after error until read
// [R19] seek complete frozen after error, set standby
// [R20] drq flag, fault and corrected read zero
// [R21] index pulses once per revolution
// [R22] error bit set on failure, cleared on command
// [R23] reset values 50h, A0h, 01h, 01h
module tfs_regs
   import tfs_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire tfs_host_s  host,
   input  wire logic       cmd_write,
   input  wire tfs_cmpl_s  cmpl,
   input  wire logic       power_ready,
   input  wire logic       seek_start,
   input  wire logic       seek_settled,
   input  wire logic       low_power,
   input  wire logic       data_ready,
   input  wire logic       index_pin,
   input  wire logic       irq_set,
   output logic [7:0]      rdata,
   output logic            irq,
   output logic            lba_mode,
   output logic [16:0]     req_sectors,
   output logic            cmd_start,
   output logic [7:0]      feature
);
   tfs_state_s st_ff;
   tfs_state_s nxt_st;
   logic       idx_m_ff;
   logic       idx_s_ff;
   logic [7:0] stat_v;

   // index arrives from the spindle, unrelated to core_clk
   always_ff @(posedge core_clk) begin
      if (rst) begin
         idx_m_ff <= 1'b0;
         idx_s_ff <= 1'b0;
      end else begin
         idx_m_ff <= index_pin;
         idx_s_ff <= idx_m_ff;
      end
   end

   always_comb begin
      nxt_st = st_ff;
      stat_v = 8'h00;
      stat_v[ST_BUSY] = st_ff.busy;
      stat_v[ST_RDY]  = st_ff.rdy;
      stat_v[ST_DSC]  = st_ff.seek_complete_flag | low_power;          // see [R19]
      stat_v[ST_DRQ]  = st_ff.data_request_flag;                      // see [R20]
      stat_v[ST_IDX]  = st_ff.idx;                      // see [R21]
      stat_v[ST_ERR]  = st_ff.errf;
      nxt_st.cmd_start = 1'b0;
      nxt_st.idx = idx_s_ff;                            // see [R21]
      nxt_st.data_request_flag = data_ready & ~st_ff.busy;            // see [R20]
      if (!st_ff.rdy_hold && power_ready) begin
         nxt_st.rdy = 1'b1;                             // see [R18]
      end
      // dsc tracks the mechanics unless frozen by an error
      if (!st_ff.dsc_hold) begin
         if (seek_start) begin
            nxt_st.seek_complete_flag = 1'b0;                          // see [R19]
         end else if (seek_settled) begin
            nxt_st.seek_complete_flag = 1'b1;
         end
      end
      // read path: busy forces status on every select
      nxt_st.rdata = 8'h00;
      if (host.rd) begin
         if (st_ff.busy || host.sel == TFS_SEL_STAT) begin
            nxt_st.rdata = stat_v;                      // see [R17]
         end else begin
            unique case (host.sel)
               TFS_SEL_ERR:  nxt_st.rdata = st_ff.err & ER_ZERO_MASK; // see [R12]
               TFS_SEL_CNT:  nxt_st.rdata = st_ff.cnt;
               TFS_SEL_NUM:  nxt_st.rdata = st_ff.num;
               TFS_SEL_DEVH: nxt_st.rdata = st_ff.devh;
               default:      nxt_st.rdata = 8'h00;
            endcase
         end
         if (host.sel == TFS_SEL_STAT && !st_ff.busy) begin
            nxt_st.irq = 1'b0;                          // see [R16]
            if (st_ff.rdy_hold) begin
               nxt_st.rdy_hold = 1'b0;                  // see [R18]
               nxt_st.rdy = power_ready;
            end
            nxt_st.dsc_hold = 1'b0;                     // see [R19]
         end
      end
      // host writes, ignored while busy
      if (host.wr && !st_ff.busy) begin
         unique case (host.sel)
            TFS_SEL_FEAT: nxt_st.feat = host.wdata;
            TFS_SEL_CNT: begin
               nxt_st.cnt_prev = st_ff.cnt;
               nxt_st.cnt = host.wdata;
            end
            TFS_SEL_NUM: begin
               nxt_st.num_prev = st_ff.num;             // see [R15]
               nxt_st.num = host.wdata;
            end
            TFS_SEL_DEVH: begin
               // unit select kept but never compared
               nxt_st.devh = host.wdata;                // see [R3]
               nxt_st.devh[DH_FIX_HI] = 1'b1;           // see [R2]
               nxt_st.devh[DH_FIX_LO] = 1'b1;           // see [R2]
            end
            default: begin
            end
         endcase
      end
      if (cmd_write && !st_ff.busy && !st_ff.data_request_flag) begin
         nxt_st.busy = 1'b1;
         nxt_st.errf = 1'b0;                            // see [R22]
         nxt_st.cmd_start = 1'b1;
      end
      if (cmpl.done) begin
         nxt_st.busy = 1'b0;                            // see [R16]
         if (cmpl.diag) begin
            nxt_st.err = cmpl.diag_code;                // see [R6]
            nxt_st.errf = 1'b0;
         end else begin
            nxt_st.err = 8'h00;                         // see [R6]
            nxt_st.err[ER_CRC]  = cmpl.crc_err;         // see [R7]
            nxt_st.err[ER_UNC]  = cmpl.unc_err;         // see [R8]
            nxt_st.err[ER_SECTOR_ID_MISSING] = cmpl.sector_id_missing_err;        // see [R9]
            nxt_st.err[ER_ABT]  = cmpl.abort_err;       // see [R10]
            nxt_st.err[ER_TK0]  = cmpl.tk0_err;         // see [R11]
            nxt_st.errf = cmpl.fail;                    // see [R22]
            nxt_st.cnt = cmpl.fail ? cmpl.remain[7:0] : 8'h00;      // see [R14]
            nxt_st.cnt_prev = cmpl.fail ? cmpl.remain[15:8] : 8'h00;
            nxt_st.devh[3:0] = cmpl.head;               // see [R4] [R5]
            nxt_st.num = cmpl.sector;                   // see [R15]
            nxt_st.num_prev = cmpl.sector_prev;         // see [R15]
            if (cmpl.fail) begin
               nxt_st.rdy = 1'b0;                       // see [R18]
               nxt_st.rdy_hold = 1'b1;
               nxt_st.dsc_hold = 1'b1;                  // see [R19]
            end
         end
      end
      // set wins over a same-cycle status read
      if (irq_set || cmpl.done) begin
         nxt_st.irq = 1'b1;                             // see [R16]
      end
      if (rst) begin
         nxt_st = '0;
         nxt_st.devh = RST_DEVH;                        // see [R23]
         nxt_st.cnt = RST_CNT;
         nxt_st.num = RST_NUM;
         nxt_st.err = RST_DIAG;                         // see [R6]
         nxt_st.rdy = RST_STAT[ST_RDY];                 // see [R23]
         nxt_st.seek_complete_flag = RST_STAT[ST_DSC];
      end
   end

   always_ff @(posedge core_clk) begin
      st_ff <= nxt_st;
   end

   // outputs straight from flip-flops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lba_mode    <= RST_DEVH[DH_LBA_BIT];
         req_sectors <= 17'h00001;
      end else begin
         lba_mode <= nxt_st.devh[DH_LBA_BIT];         // see [R1]
         // 16-bit count from the previous and current count bytes; zero means maximum
         if ({nxt_st.cnt_prev, nxt_st.cnt} == 16'h0000) begin
            req_sectors <= 17'h10000;                   // see [R13]
         end else begin
            req_sectors <= {1'b0, nxt_st.cnt_prev, nxt_st.cnt};
         end
      end
   end

   assign rdata     = st_ff.rdata;
   assign irq       = st_ff.irq;
   assign cmd_start = st_ff.cmd_start;
   assign feature   = st_ff.feat;
endmodule : tfs_regs
`default_nettype wire

/* tb/tfs_regs_chk_sva.sv */
// assertions on the task file register block ports
`default_nettype none
module tfs_regs_chk
   import tfs_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rst,
   input wire tfs_host_s  host,
   input wire logic       cmd_write,
   input wire tfs_cmpl_s  cmpl,
   input wire logic       irq_set,
   input wire logic [7:0] rdata,
   input wire logic       irq,
   input wire logic       lba_mode,
   input wire logic       cmd_start
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_one; cmd_start |=> !cmd_start; endproperty
   a_one: assert property (p_one) else $error("start pulse too long");
   property p_cause; cmd_start |-> $past(cmd_write); endproperty
   a_cause: assert property (p_cause) else $error("start without command");
   property p_done; cmpl.done |=> irq; endproperty
   a_done: assert property (p_done) else $error("no irq after done");
   property p_ack; host.rd && host.sel == TFS_SEL_STAT && !cmpl.done && !irq_set
      ##1 !rdata[ST_BUSY] |-> !irq; endproperty
   a_ack: assert property (p_ack) else $error("irq kept after read");
   property p_ezero; host.rd && host.sel == TFS_SEL_ERR |=> !rdata[5] && !rdata[3]; endproperty
   a_ezero: assert property (p_ezero) else $error("error zero bits set");
   property p_szero; host.rd && host.sel == TFS_SEL_STAT |=> !rdata[5] && !rdata[2]; endproperty
   a_szero: assert property (p_szero) else $error("status zero bits set");
   property p_fix; host.rd && host.sel == TFS_SEL_DEVH |=> rdata[DH_FIX_HI]; endproperty
   a_fix: assert property (p_fix) else $error("dev/head bit 7 clear");
   property p_lba; !(host.wr && host.sel == TFS_SEL_DEVH) |=> $stable(lba_mode); endproperty
   a_lba: assert property (p_lba) else $error("lba mode moved");
endmodule : tfs_regs_chk
bind tfs_regs tfs_regs_chk i_chk (.core_clk, .rst, .host, .cmd_write, .cmpl, .irq_set,
   .rdata, .irq, .lba_mode, .cmd_start);
`default_nettype wire

/* tb/tfs_host_model.sv */
// host adapter model on the task file port
`default_nettype none
module tfs_host_model
   import tfs_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic [7:0] rdata,
   output var  tfs_host_s  host
);
   timeunit 1ns;
   timeprecision 1ps;
   initial host = '0;
   // released lines show junk so stale values never pass
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      host = '{rd: 1'b0, wr: 1'b1, sel: s, wdata: d};
      @(posedge core_clk);
      #1;
      host = '{rd: 1'b0, wr: 1'b0, sel: ~s, wdata: ~d};
   endtask : wr
   task automatic rd(input logic [2:0] s, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      host = '{rd: 1'b1, wr: 1'b0, sel: s, wdata: 8'hA5};
      @(posedge core_clk);
      #1;
      host = '{rd: 1'b0, wr: 1'b0, sel: ~s, wdata: 8'h5A};
      d = rdata;
   endtask : rd
endmodule : tfs_host_model
`default_nettype wire

/* tb/test_tfs_regs.sv */
// bench for the task file register block
`default_nettype none
module test_tfs_regs;
   import tfs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, rst, cmd_write, seek_start, seek_settled, low_power, data_ready;
   logic        irq, lba_mode, cmd_start, index_pin, irq_set, power_ready;
   logic [7:0]  rdata, feature;
   logic [16:0] req_sectors;
   tfs_host_s   host;
   tfs_cmpl_s   cmpl, c;
   int          n_mismatch, samples_checked;
   tfs_host_model i_host (.core_clk, .rdata, .host);
   tfs_regs i_dut (.core_clk, .rst, .host, .cmd_write, .cmpl, .power_ready, .seek_start,
      .seek_settled, .low_power, .data_ready, .index_pin, .irq_set, .rdata, .irq,
      .lba_mode, .req_sectors, .cmd_start, .feature);
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic complete_run;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask : tick
   task automatic rc(input logic [2:0] s, input logic [7:0] e);
      logic [7:0] d;
      i_host.rd(s, d);
      chk(17'(d), 17'(e));
   endtask : rc
   // busy read of count must mirror status
   task automatic run_cmd(input tfs_cmpl_s k);
      tick;
      cmd_write = 1'b1;
      tick;
      cmd_write = 1'b0;
      chk(17'(cmd_start), 17'h1);
      rc(TFS_SEL_CNT, 8'hD0);
      cmpl = k;
      cmpl.done = 1'b1;
      tick;
      cmpl = '0;
      chk(17'(irq), 17'h1);
   endtask : run_cmd
   task automatic t_setup;
      rc(TFS_SEL_STAT, RST_STAT);
      rc(TFS_SEL_DEVH, 8'hA0);
      rc(TFS_SEL_NUM, 8'h01);
      rc(TFS_SEL_ERR, 8'h00);
      chk(req_sectors, 17'h00001);
      i_host.wr(TFS_SEL_DEVH, 8'h50);
      rc(TFS_SEL_DEVH, 8'hF0);
      chk(17'(lba_mode), 17'h1);
      i_host.wr(TFS_SEL_FEAT, 8'h3C);
      chk(17'(feature), 17'h0003C);
      i_host.wr(TFS_SEL_CNT, 8'h00);
      i_host.wr(TFS_SEL_CNT, 8'h00);
      chk(req_sectors, 17'h10000);
   endtask : t_setup
   task automatic t_ok;
      c = '0;
      c.head = 4'h9;
      c.sector = 8'h22;
      run_cmd(c);
      rc(TFS_SEL_STAT, 8'h50);
      chk(17'(irq), 17'h0);
      rc(TFS_SEL_ERR, 8'h00);
      rc(TFS_SEL_CNT, 8'h00);
      rc(TFS_SEL_NUM, 8'h22);
      rc(TFS_SEL_DEVH, 8'hF9);
   endtask : t_ok
   task automatic t_fail;
      c = '0;
      c.fail = 1'b1;
      c.abort_err = 1'b1;
      c.unc_err = 1'b1;
      c.remain = 16'h0003;
      run_cmd(c);
      rc(TFS_SEL_ERR, 8'h44);
      rc(TFS_SEL_CNT, 8'h03);
      rc(TFS_SEL_STAT, 8'h11);
      rc(TFS_SEL_STAT, 8'h51);
      c = '0;
      c.fail = 1'b1;
      c.crc_err = 1'b1;
      c.sector_id_missing_err = 1'b1;
      c.tk0_err = 1'b1;
      run_cmd(c);
      rc(TFS_SEL_ERR, 8'h92);
      rc(TFS_SEL_STAT, 8'h11);
   endtask : t_fail
   // error flag from the last failed command still stands here
   task automatic t_seek;
      seek_start = 1'b1;
      tick;
      seek_start = 1'b0;
      rc(TFS_SEL_STAT, 8'h41);
      low_power = 1'b1;
      rc(TFS_SEL_STAT, 8'h51);
      low_power = 1'b0;
      seek_settled = 1'b1;
      tick;
      seek_settled = 1'b0;
      data_ready = 1'b1;
      rc(TFS_SEL_STAT, 8'h59);
      cmd_write = 1'b1;
      tick;
      cmd_write = 1'b0;
      chk(17'(cmd_start), 17'h0);
   endtask : t_seek
   // index passes two sync flops and the status flop
   task automatic t_misc;
      data_ready = 1'b0;
      index_pin = 1'b1;
      tick;
      tick;
      rc(TFS_SEL_STAT, 8'h53);
      index_pin = 1'b0;
      tick;
      tick;
      rc(TFS_SEL_STAT, 8'h51);
      irq_set = 1'b1;
      tick;
      irq_set = 1'b0;
      chk(17'(irq), 17'h1);
      rc(TFS_SEL_STAT, 8'h51);
      chk(17'(irq), 17'h0);
      c = '0;
      c.fail = 1'b1;
      run_cmd(c);
      power_ready = 1'b0;
      rc(TFS_SEL_STAT, 8'h11);
      rc(TFS_SEL_STAT, 8'h11);
      power_ready = 1'b1;
      rc(TFS_SEL_STAT, 8'h51);
   endtask : t_misc
   initial begin
      #5000;
      n_mismatch++;
      complete_run;
   end
   initial begin
      rst = 1'b1;
      {cmd_write, seek_start, seek_settled, low_power, data_ready} = 5'h00;
      {index_pin, irq_set, power_ready} = 3'h1;
      cmpl = '0;
      repeat (2) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_setup;
      t_ok;
      t_fail;
      t_seek;
      t_misc;
      complete_run;
   end
endmodule : test_tfs_regs
`default_nettype wire
